// ===== pkg/msr_regs.vh
`ifndef MSR_REGS_VH
`define MSR_REGS_VH

// Serial target address of the controller
`define MSR_DEV_ADDR 7'h55

// Internal word addresses, 14 bits wide
`define MSR_ADDR_W 14
`define MSR_ADDR_STATUS 14'h0000
`define MSR_ADDR_CMD 14'h0001
`define MSR_ADDR_MPCW 14'h0385
`define MSR_ADDR_ANGLE 14'h0386
`define MSR_ADDR_SHAPED 14'h0387
`define MSR_ADDR_CURVE 14'h0388
`define MSR_ADDR_SUPPLY 14'h038A
`define MSR_ADDR_CURRENT 14'h038B
`define MSR_ADDR_TACH 14'h038C
`define MSR_ADDR_BEMF 14'h038D

// Status word field positions
`define MSR_ST_MODE_LSB 0
`define MSR_ST_STATE_LSB 8
`define MSR_ST_FAULT_LSB 16
`define MSR_ST_CLAMP_LSB 24
`define MSR_ST_RSVD_BIT 31

// Command register fields
`define MSR_CMD_DIR_BIT 16
`define MSR_DEMAND_MAX 16'h7FFF

// Multipurpose word fields
`define MSR_MP_CODE_LSB 16

// Frame layout: address byte marker bit and data byte count
`define MSR_ADDR_MARK_BIT 7
`define MSR_DATA_BYTES 4

// Reset values
`define MSR_DEMAND_RST 16'h0000
`define MSR_DIR_RST 1'b0
`define MSR_MP_RST 32'h0000_0000

`endif

// ===== logic/msr_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs; idle high like the serial lines
module msr_sync #(
    parameter WIDTH = 2
) (
    input wire ref_clk,
    input wire rstn,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= {WIDTH{1'b1}};
            dout <= {WIDTH{1'b1}};
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// ===== logic/msr_read_mux.v
`timescale 1ns/1ps
`include "msr_regs.vh"
// Builds the 32-bit read word for one internal address
module msr_read_mux (
    input wire [13:0] addr,
    input wire [7:0] control_mode_field,
    input wire [7:0] control_sequence_state,
    input wire [7:0] fault_flags,
    input wire [6:0] clamp_flags,
    input wire [15:0] demand,
    input wire direction,
    input wire [31:0] mp_word,
    input wire [8:0] start_rotor_angle,
    input wire [15:0] start_rotor_speed,
    input wire [15:0] shaped_command_value,
    input wire [1:0] position_detect_result,
    input wire [7:0] windmill_result,
    input wire [15:0] curve_input_value,
    input wire [15:0] supply_voltage,
    input wire [11:0] voltage_demand,
    input wire [15:0] supply_current,
    input wire [31:0] tach_output_frequency,
    input wire [15:0] back_emf_voltage,
    input wire back_emf_valid,
    output reg [31:0] rd_word
);
    // Address decode; unmapped addresses read as zero
    always @* begin
        rd_word = 32'h0000_0000;
        case (addr)
            `MSR_ADDR_STATUS:
                rd_word = {1'b0, clamp_flags, fault_flags,
                    control_sequence_state,
                    control_mode_field};
            `MSR_ADDR_CMD:
                rd_word = {15'h0, direction, demand};
            `MSR_ADDR_MPCW:
                rd_word = mp_word;
            `MSR_ADDR_ANGLE:
                rd_word = {start_rotor_speed, {7{start_rotor_angle[8]}},
                    start_rotor_angle};
            `MSR_ADDR_SHAPED:
                rd_word = {windmill_result, 6'h00, position_detect_result,
                    shaped_command_value};
            `MSR_ADDR_CURVE:
                rd_word = {16'h0000, curve_input_value};
            `MSR_ADDR_SUPPLY:
                rd_word = {4'h0, voltage_demand,
                    supply_voltage};
            `MSR_ADDR_CURRENT:
                rd_word = {16'h0000, supply_current};
            `MSR_ADDR_TACH:
                rd_word = tach_output_frequency;
            `MSR_ADDR_BEMF:
                // Outside closed-loop observer operation (back_emf_valid low) the value reads as zero
                rd_word = {16'h0000, back_emf_valid ? back_emf_voltage :
                    16'h0000};
            default:
                rd_word = 32'h0000_0000;
        endcase
    end
endmodule

// ===== logic/msr_status_port.v
`timescale 1ns/1ps
`include "msr_regs.vh"
module msr_status_port #(
    parameter [6:0] DEV_ADDR = `MSR_DEV_ADDR
) (
    input wire ref_clk,
    input wire rstn,
    input wire scl,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_n,
    input wire [7:0] control_mode_field,
    input wire [7:0] control_sequence_state,
    input wire [7:0] fault_flags,
    input wire [6:0] clamp_flags,
    input wire [8:0] start_rotor_angle,
    input wire [15:0] start_rotor_speed,
    input wire [15:0] shaped_command_value,
    input wire [1:0] position_detect_result,
    input wire [7:0] windmill_result,
    input wire [15:0] curve_input_value,
    input wire [15:0] supply_voltage,
    input wire [11:0] voltage_demand,
    input wire [15:0] supply_current,
    input wire [31:0] tach_output_frequency,
    input wire [15:0] back_emf_voltage,
    input wire back_emf_valid,
    input wire mp_done,
    output wire [15:0] host_demand,
    output wire host_direction,
    output reg host_cmd_stb,
    output wire [15:0] mp_code,
    output wire [15:0] mp_data,
    output reg mp_stb
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_RX = 3'd1;
    localparam [2:0] ST_ACK = 3'd2;
    localparam [2:0] ST_TX = 3'd3;
    localparam [2:0] ST_MACK = 3'd4;

    // Frame phases: target address, two address bytes, then data bytes
    localparam [2:0] PH_DEV = 3'd0;
    localparam [2:0] PH_ALO = 3'd1;
    localparam [2:0] PH_AHI = 3'd2;
    localparam [2:0] PH_D0 = 3'd3;
    localparam [2:0] PH_D3 = 3'd6;

    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire [13:0] rd_addr;
    wire [31:0] rd_word;
    wire [31:0] wr_full;

    reg scl_p_q;
    reg sda_p_q;
    reg [2:0] st_q;
    reg [2:0] phase_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] sh_q;
    reg rw_q;
    reg [13:0] addr_q;
    reg [31:0] wdata_q;
    reg [31:0] rdata_q;
    reg sda_low_q;
    reg mack_q;
    reg wr_stb_q;
    reg [31:0] wr_data_q;
    reg [15:0] demand_q;
    reg dir_q;
    reg [31:0] mp_q;

    // Both serial lines come from pins and are synchronised first
    msr_sync #(
        .WIDTH(2)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .din({scl, sda_i}),
        .dout({scl_s, sda_s})
    );

    // Delayed copies of the synchronised lines for edge finding
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    // Data moving while the clock is high marks frame boundaries
    assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // Read address is only sampled when the high address byte completes
    assign rd_addr = {sh_q[6:0], addr_q[6:0]};
    // Bytes arrive low byte first, so the last byte lands on top
    assign wr_full = {sh_q, wdata_q[31:8]};

    msr_read_mux u_mux (
        .addr(rd_addr),
        .control_mode_field(control_mode_field),
        .control_sequence_state(control_sequence_state),
        .fault_flags(fault_flags),
        .clamp_flags(clamp_flags),
        .demand(demand_q),
        .direction(dir_q),
        .mp_word(mp_q),
        .start_rotor_angle(start_rotor_angle),
        .start_rotor_speed(start_rotor_speed),
        .shaped_command_value(shaped_command_value),
        .position_detect_result(position_detect_result),
        .windmill_result(windmill_result),
        .curve_input_value(curve_input_value),
        .supply_voltage(supply_voltage),
        .voltage_demand(voltage_demand),
        .supply_current(supply_current),
        .tach_output_frequency(tach_output_frequency),
        .back_emf_voltage(back_emf_voltage),
        .back_emf_valid(back_emf_valid),
        .rd_word(rd_word)
    );

    // Open-drain data line: only ever pull low, release otherwise
    assign sda_o = 1'b0;
    assign sda_oe_n = ~sda_low_q;

    // Serial frame engine; samples on clock rise, changes data on fall
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            phase_q <= PH_DEV;
            bit_cnt_q <= 4'h0;
            sh_q <= 8'h00;
            rw_q <= 1'b0;
            addr_q <= 14'h0000;
            wdata_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            sda_low_q <= 1'b0;
            mack_q <= 1'b0;
            wr_stb_q <= 1'b0;
            wr_data_q <= 32'h0000_0000;
        end else begin
            wr_stb_q <= 1'b0;
            if (start_det) begin
                // Start or repeated start restarts the frame
                st_q <= ST_RX;
                phase_q <= PH_DEV;
                bit_cnt_q <= 4'h0;
                sda_low_q <= 1'b0;
            end else if (stop_det) begin
                st_q <= ST_IDLE;
                sda_low_q <= 1'b0;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        sda_low_q <= 1'b0;
                    end
                    ST_RX: begin
                        if (scl_rise && bit_cnt_q != 4'h8) begin
                            sh_q <= {sh_q[6:0], sda_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            st_q <= ST_ACK;
                            sda_low_q <= 1'b1;
                            case (phase_q)
                                PH_DEV: begin
                                    if (sh_q[7:1] == DEV_ADDR) begin
                                        rw_q <= sh_q[0];
                                    end else begin
                                        // Not addressed: stay off the line
                                        st_q <= ST_IDLE;
                                        sda_low_q <= 1'b0;
                                    end
                                end
                                PH_ALO: begin
                                    if (sh_q[`MSR_ADDR_MARK_BIT]) begin
                                        addr_q[6:0] <= sh_q[6:0];
                                    end else begin
                                        st_q <= ST_IDLE;
                                        sda_low_q <= 1'b0;
                                    end
                                end
                                PH_AHI: begin
                                    if (sh_q[`MSR_ADDR_MARK_BIT]) begin
                                        addr_q[13:7] <= sh_q[6:0];
                                        // Snapshot keeps the four bytes coherent
                                        rdata_q <= rd_word;
                                    end else begin
                                        st_q <= ST_IDLE;
                                        sda_low_q <= 1'b0;
                                    end
                                end
                                PH_D3: begin
                                    // Fourth byte completes the word
                                    wr_data_q <= wr_full;
                                    wr_stb_q <= 1'b1;
                                end
                                3'd3, 3'd4, 3'd5: begin
                                    wdata_q <= wr_full;
                                end
                                default: begin
                                    // Surplus bytes are not acknowledged
                                    st_q <= ST_IDLE;
                                    sda_low_q <= 1'b0;
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            phase_q <= phase_q + 3'd1;
                            if (phase_q == PH_AHI && rw_q) begin
                                // Hand the line to the first read byte
                                st_q <= ST_TX;
                                sh_q <= rdata_q[7:0];
                                rdata_q <= {8'h00, rdata_q[31:8]};
                                sda_low_q <= ~rdata_q[7];
                            end else begin
                                st_q <= ST_RX;
                                sda_low_q <= 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_q == 4'h8) begin
                                bit_cnt_q <= 4'h0;
                                st_q <= ST_MACK;
                                sda_low_q <= 1'b0;
                            end else begin
                                sh_q <= {sh_q[6:0], 1'b0};
                                sda_low_q <= ~sh_q[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            mack_q <= ~sda_s;
                        end else if (scl_fall) begin
                            // Host NACK or fourth byte ends the read
                            if (mack_q && phase_q != PH_D3) begin
                                phase_q <= phase_q + 3'd1;
                                st_q <= ST_TX;
                                sh_q <= rdata_q[7:0];
                                rdata_q <= {8'h00, rdata_q[31:8]};
                                sda_low_q <= ~rdata_q[7];
                            end else begin
                                st_q <= ST_IDLE;
                                sda_low_q <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        st_q <= ST_IDLE;
                        sda_low_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Writable words; every other address is read-only and ignored
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            demand_q <= `MSR_DEMAND_RST;
            dir_q <= `MSR_DIR_RST;
            mp_q <= `MSR_MP_RST;
            host_cmd_stb <= 1'b0;
            mp_stb <= 1'b0;
        end else begin
            host_cmd_stb <= 1'b0;
            mp_stb <= 1'b0;
            if (wr_stb_q && addr_q == `MSR_ADDR_CMD) begin
                // Demand above the range saturates rather than wraps
                if (wr_data_q[15]) begin
                    demand_q <= `MSR_DEMAND_MAX;
                end else begin
                    demand_q <= wr_data_q[15:0];
                end
                dir_q <= wr_data_q[`MSR_CMD_DIR_BIT];
                host_cmd_stb <= 1'b1;
            end
            if (wr_stb_q && addr_q == `MSR_ADDR_MPCW) begin
                // A new instruction wins over a same-cycle completion
                mp_q <= wr_data_q;
                mp_stb <= 1'b1;
            end else if (mp_done) begin
                // Completion acknowledged by zeroing the word
                mp_q <= `MSR_MP_RST;
            end
            // Writes to other addresses fall through untouched
        end
    end

    assign host_demand = demand_q;
    assign host_direction = dir_q;
    assign mp_data = mp_q[15:0];
    assign mp_code = mp_q[31:`MSR_MP_CODE_LSB];
endmodule

// ===== testbench/msr_status_port_assertions.sv
`timescale 1ns/1ps
// Watches the host-facing registers and the data pin of the status port
module msr_status_port_checker (
    input wire ref_clk,
    input wire rstn,
    input wire scl,
    input wire sda_o,
    input wire sda_oe_n,
    input wire mp_done,
    input wire [15:0] host_demand,
    input wire host_direction,
    input wire host_cmd_stb,
    input wire [15:0] mp_code,
    input wire [15:0] mp_data,
    input wire mp_stb
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // Saturation keeps the demand inside its range whatever was written
    property p_demand_range;
        host_demand <= 16'h7FFF;
    endproperty
    a_demand_range: assert property (p_demand_range)
        else $error("demand above range");
    property p_cmd_pulse;
        host_cmd_stb |=> !host_cmd_stb;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse)
        else $error("command strobe longer than one cycle");
    // Command outputs move only with a committed write
    property p_cmd_hold;
        $changed(host_demand) || $changed(host_direction) |-> host_cmd_stb;
    endproperty
    a_cmd_hold: assert property (p_cmd_hold)
        else $error("command changed without strobe");
    property p_mp_pulse;
        mp_stb |=> !mp_stb;
    endproperty
    a_mp_pulse: assert property (p_mp_pulse)
        else $error("multipurpose strobe longer than one cycle");
    property p_mp_hold;
        $changed({mp_code, mp_data}) |-> mp_stb || $past(mp_done);
    endproperty
    a_mp_hold: assert property (p_mp_hold)
        else $error("multipurpose word changed without cause");
    // Finished instruction zeroes the word unless a write lands
    property p_mp_clear;
        mp_done |=> mp_stb || {mp_code, mp_data} == 32'h0000_0000;
    endproperty
    a_mp_clear: assert property (p_mp_clear)
        else $error("multipurpose word not cleared");
    property p_one_target;
        !(host_cmd_stb && mp_stb);
    endproperty
    a_one_target: assert property (p_one_target)
        else $error("two registers written by one frame");
    // Open drain: the pin value is only ever a low
    property p_open_drain;
        sda_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data pin driven high");
    // Device moves the data line only while the serial clock is low
    property p_drive_on_low;
        $changed(sda_oe_n) |-> !scl;
    endproperty
    a_drive_on_low: assert property (p_drive_on_low)
        else $error("data line moved while clock high");
    property p_reset_vals;
        $rose(rstn) |-> host_demand == 16'h0000 && !host_direction &&
            {mp_code, mp_data} == 32'h0000_0000 && sda_oe_n;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("wrong value after reset");
    // A stuck low data line would hang the bus for every host
    property p_release;
        $fell(sda_oe_n) |-> ##[1:120] $rose(sda_oe_n);
    endproperty
    a_release: assert property (p_release)
        else $error("data line held low too long");
    c_cmd: cover property (host_cmd_stb && host_direction);
    c_mp: cover property (mp_stb);
    c_done: cover property (mp_done ##1 !mp_stb);
endmodule

bind msr_status_port msr_status_port_checker u_chk (.ref_clk(ref_clk),
    .rstn(rstn), .scl(scl), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .mp_done(mp_done),
    .host_demand(host_demand), .host_direction(host_direction),
    .host_cmd_stb(host_cmd_stb), .mp_code(mp_code), .mp_data(mp_data),
    .mp_stb(mp_stb));

// ===== testbench/msr_host_model.sv
`timescale 1ns/1ps
// Serial host: makes the 80 ns clock and pulls the data line low
module msr_host_model (
    input wire ref_clk,
    input wire sda,
    output logic scl,
    output logic sda_pull
);
    // Marker bit of the low address byte; cleared only to test refusal
    logic addr_mark = 1'b1;
    // Clock idles high between frames, line released to its pull-up
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Quarter serial periods, moving just after a system clock edge
    task automatic qtr(input int n);
        repeat (2 * n) @(posedge ref_clk);
        #1;
    endtask
    // One bit out, line sampled in mid high phase
    task automatic bit_io(input logic b, output logic s);
        sda_pull = ~b;
        qtr(1);
        scl = 1'b1;
        qtr(1);
        s = sda;
        qtr(1);
        scl = 1'b0;
        qtr(1);
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic rel,
                           output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(rel, ack);
    endtask
    // Whole frame; data bytes go least significant first
    task automatic frame(input logic [6:0] dev, input logic rd,
                         input logic [13:0] addr, inout logic [31:0] data,
                         output logic ok);
        logic [7:0] rx;
        logic a;
        ok = 1'b1;
        sda_pull = 1'b1;
        qtr(1);
        scl = 1'b0;
        qtr(1);
        byte_io({dev, rd}, 1'b1, rx, a);
        ok &= ~a;
        byte_io({addr_mark, addr[6:0]}, 1'b1, rx, a);
        ok &= ~a;
        byte_io({1'b1, addr[13:7]}, 1'b1, rx, a);
        ok &= ~a;
        for (int k = 0; k < 4; k++) begin
            // Last read byte is refused by the host
            byte_io(rd ? 8'hFF : data[8*k +: 8], !rd || k == 3, rx, a);
            if (rd)
                data[8*k +: 8] = rx;
            else
                ok &= ~a;
        end
        sda_pull = 1'b1;
        qtr(1);
        scl = 1'b1;
        qtr(1);
        sda_pull = 1'b0;
        qtr(2);
    endtask
endmodule

// ===== testbench/motor_status_register_map_bench.sv
`timescale 1ns/1ps
`include "msr_regs.vh"
// Frames from the host model against the status port registers
module motor_status_register_map_bench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] mode = 8'h00, state = 8'h00, faults = 8'h00, wind = 8'h3C;
    logic [6:0] clamps = 7'h00;
    logic [8:0] angle = 9'h100;
    logic [15:0] speed = 16'h8001, shaped = 16'h8000, curve = 16'h2468;
    logic [15:0] vbus = 16'h1357, ibus = 16'hF00D, bemf = 16'hC001;
    logic [11:0] vcmd = 12'hABC;
    logic [31:0] tach = 32'h8765_4321;
    logic [1:0] pdr = 2'h0;
    logic bemf_ok = 1'b1;
    logic mp_done = 1'b0;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int cmd_n = 0;
    int mp_n = 0;
    logic [31:0] d;
    logic ok;
    wire scl, sda, host_pull, sda_o, sda_oe_n, host_direction;
    wire host_cmd_stb, mp_stb;
    wire [15:0] host_demand, mp_code, mp_data;

    // Pull-up wins unless someone pulls low
    assign sda = (host_pull || !sda_oe_n) ? 1'b0 : 1'b1;
    always #5 ref_clk = ~ref_clk;

    msr_status_port dut (.ref_clk(ref_clk), .rstn(rstn), .scl(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .control_mode_field(mode), .control_sequence_state(state),
        .fault_flags(faults), .clamp_flags(clamps),
        .start_rotor_angle(angle), .start_rotor_speed(speed),
        .shaped_command_value(shaped), .position_detect_result(pdr),
        .windmill_result(wind), .curve_input_value(curve),
        .supply_voltage(vbus), .voltage_demand(vcmd),
        .supply_current(ibus), .tach_output_frequency(tach),
        .back_emf_voltage(bemf), .back_emf_valid(bemf_ok),
        .mp_done(mp_done), .host_demand(host_demand),
        .host_direction(host_direction), .host_cmd_stb(host_cmd_stb),
        .mp_code(mp_code), .mp_data(mp_data), .mp_stb(mp_stb));
    msr_host_model u_host (.ref_clk(ref_clk), .sda(sda), .scl(scl),
        .sda_pull(host_pull));

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [31:0] v);
        u_host.frame(`MSR_DEV_ADDR, 1'b0, a, v, ok);
        check({31'h0, ok}, 32'h1);
    endtask
    task automatic rdc(input logic [13:0] a, input logic [31:0] want);
        d = 32'h0;
        u_host.frame(`MSR_DEV_ADDR, 1'b1, a, d, ok);
        check({31'h0, ok}, 32'h1);
        check(d, want);
    endtask

    // Strobe counters and the hang limit
    always @(posedge ref_clk) begin
        cmd_n <= cmd_n + int'(host_cmd_stb);
        mp_n <= mp_n + int'(mp_stb);
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        // Every mode and state code, walking flags, bit 31 never set
        for (int k = 0; k < 8; k++) begin
            mode = 8'(k % 6);
            state = 8'(k);
            faults = 8'(1 << k);
            clamps = ~7'(1 << k);
            rdc(`MSR_ADDR_STATUS, {1'b0, clamps, faults, state, mode});
        end
        wr(`MSR_ADDR_STATUS, 32'hFFFF_FFFF);
        rdc(`MSR_ADDR_STATUS, {1'b0, clamps, faults, state, mode});
        wr(`MSR_ADDR_TACH, 32'h0000_0000);
        rdc(`MSR_ADDR_TACH, tach);
        // Demand edges: full scale, saturation, zero with direction
        wr(`MSR_ADDR_CMD, 32'h0001_7FFF);
        check({15'h0, host_direction, host_demand}, 32'h0001_7FFF);
        rdc(`MSR_ADDR_CMD, 32'h0001_7FFF);
        wr(`MSR_ADDR_CMD, 32'hFFFE_8000);
        check({15'h0, host_direction, host_demand}, 32'h0000_7FFF);
        wr(`MSR_ADDR_CMD, 32'h0001_0000);
        check({15'h0, host_direction, host_demand}, 32'h0001_0000);
        check(32'(cmd_n), 32'h3);
        // Instruction word, then cleared when firmware finishes
        wr(`MSR_ADDR_MPCW, 32'h0001_1234);
        check({mp_code, mp_data}, 32'h0001_1234);
        rdc(`MSR_ADDR_MPCW, 32'h0001_1234);
        mp_done = 1'b1;
        @(posedge ref_clk);
        #1;
        mp_done = 1'b0;
        rdc(`MSR_ADDR_MPCW, 32'h0000_0000);
        check(32'(mp_n), 32'h1);
        // Fixed-address variables
        rdc(`MSR_ADDR_ANGLE, {speed, {7{angle[8]}}, angle});
        for (int k = 0; k < 4; k++) begin
            pdr = 2'(k);
            rdc(`MSR_ADDR_SHAPED, {wind, 6'h00, pdr, shaped});
        end
        rdc(`MSR_ADDR_CURVE, {16'h0000, curve});
        rdc(`MSR_ADDR_SUPPLY, {4'h0, vcmd, vbus});
        rdc(`MSR_ADDR_CURRENT, {16'h0000, ibus});
        rdc(`MSR_ADDR_BEMF, {16'h0000, bemf});
        bemf_ok = 1'b0;
        rdc(`MSR_ADDR_BEMF, 32'h0000_0000);
        rdc(14'h3FFF, 32'h0000_0000);
        // Address byte without its marker bit is refused, no write lands
        u_host.addr_mark = 1'b0;
        d = 32'h0000_1111;
        u_host.frame(`MSR_DEV_ADDR, 1'b0, `MSR_ADDR_CMD, d, ok);
        u_host.addr_mark = 1'b1;
        check({31'h0, ok}, 32'h0);
        check(32'(cmd_n), 32'h3);
        // Another target address is refused, then service resumes
        u_host.frame(7'h2A, 1'b1, `MSR_ADDR_STATUS, d, ok);
        check({31'h0, ok}, 32'h0);
        rdc(`MSR_ADDR_CMD, 32'h0001_0000);
        tally_and_finish();
    end
endmodule
